// ---- pkg/otpw_defs.svh ----
// Constants of the one-time-programmable wiper controller
`ifndef OTPW_DEFS_SVH
`define OTPW_DEFS_SVH

// Wiper code
`define OTPW_CODE_W        6
`define OTPW_TAP_N         64
`define OTPW_CODE_MID      6'h20

// Instruction byte fields
`define OTPW_BURN_BIT      7
`define OTPW_CODE_HI       5

// Slave address byte: fixed pattern, select bit, then read/write in bit 0
`define OTPW_ADDR_PATTERN  6'h16

// Validation status encodings
`define OTPW_ST_READY      2'h0
`define OTPW_ST_TEST_FAIL  2'h1
`define OTPW_ST_FATAL      2'h2
`define OTPW_ST_LOCKED     2'h3

// Internal programming clock
`define OTPW_REF_PERIOD_NS 4
`define OTPW_TICK_NS       1000
`define OTPW_TICK_CYCLES   (`OTPW_TICK_NS / `OTPW_REF_PERIOD_NS)

`endif

// ---- pkg/otpw_pkg.sv ----
// Types shared by the wiper controller and its serial slave
package otpw_pkg;

    typedef enum logic [2:0] {
        SQ_LOAD,
        SQ_IDLE,
        SQ_TEST,
        SQ_DATA,
        SQ_CMP,
        SQ_LOCK,
        SQ_DONE
    } otpw_seq_t;

    // One bit per physical fuse: blow strobes out, sense levels in
    typedef struct packed {
        logic       lock;
        logic       test;
        logic [5:0] data;
    } otpw_fuse_t;

    // Byte handed from the serial slave after a write data byte
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } otpw_wr_t;

endpackage

// ---- design/otpw_serial_slave.sv ----
// Two-wire serial slave: address match, write byte capture, read byte shift
`timescale 1ns/1ns
`include "otpw_defs.svh"
module otpw_serial_slave
(
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  wire logic             addr_select_pin,
    input  wire logic [7:0]       rd_byte,
    output otpw_pkg::otpw_wr_t    wr
);
    import otpw_pkg::*;

    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR,
        SL_AACK,
        SL_WDATA,
        SL_WACK,
        SL_RDATA,
        SL_RACK,
        SL_RLOAD
    } otpw_sl_t;

    otpw_sl_t   state_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic [7:0] sr_reg;
    logic [3:0] cnt_reg;
    logic       oe_reg;
    logic       rw_reg;
    otpw_wr_t   wr_reg;

    wire scl_rise  = scl_in & ~scl_d_reg;
    wire scl_fall  = ~scl_in & scl_d_reg;
    wire start_ev  = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire stop_ev   = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    wire addr_hit  = (sr_reg[7:2] == `OTPW_ADDR_PATTERN)
                   && (sr_reg[1] == addr_select_pin);

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;
    assign wr      = wr_reg;

    always_ff @(posedge ref_clk)
    begin
        scl_d_reg <= scl_in;
        sda_d_reg <= sda_in;
        wr_reg.valid <= 1'b0;
        if (srst)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= SL_IDLE;
            sr_reg    <= 8'h00;
            cnt_reg   <= 4'h0;
            oe_reg    <= 1'b0;
            rw_reg    <= 1'b0;
            wr_reg    <= '0;
        end
        else if (start_ev)
        begin
            state_reg <= SL_ADDR;
            cnt_reg   <= 4'h0;
            oe_reg    <= 1'b0;
        end
        else if (stop_ev)
        begin
            state_reg <= SL_IDLE;
            oe_reg    <= 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (state_reg)
                SL_ADDR, SL_WDATA:
                begin
                    sr_reg  <= {sr_reg[6:0], sda_in};
                    cnt_reg <= cnt_reg + 4'h1;
                end
                SL_RDATA: cnt_reg <= cnt_reg + 4'h1;
                // Master not-acknowledge ends the read
                SL_RACK:  state_reg <= sda_in ? SL_IDLE : SL_RLOAD;
                default:  ;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (state_reg)
                SL_ADDR:
                    if (cnt_reg == 4'h8)
                    begin
                        rw_reg    <= sr_reg[0];
                        oe_reg    <= addr_hit;
                        state_reg <= addr_hit ? SL_AACK : SL_IDLE;
                    end
                SL_AACK, SL_RLOAD:
                begin
                    cnt_reg <= 4'h0;
                    if (rw_reg)
                    begin
                        oe_reg    <= ~rd_byte[7];
                        sr_reg    <= {rd_byte[6:0], 1'b0};
                        state_reg <= SL_RDATA;
                    end
                    else
                    begin
                        oe_reg    <= 1'b0;
                        state_reg <= SL_WDATA;
                    end
                end
                SL_WDATA:
                    if (cnt_reg == 4'h8)
                    begin
                        oe_reg       <= 1'b1;
                        wr_reg.valid <= 1'b1;
                        wr_reg.data  <= sr_reg;
                        state_reg    <= SL_WACK;
                    end
                SL_WACK:
                begin
                    oe_reg    <= 1'b0;
                    cnt_reg   <= 4'h0;
                    state_reg <= SL_WDATA;
                end
                SL_RDATA:
                    if (cnt_reg == 4'h8)
                    begin
                        oe_reg    <= 1'b0;
                        state_reg <= SL_RACK;
                    end
                    else
                    begin
                        oe_reg <= ~sr_reg[7];
                        sr_reg <= {sr_reg[6:0], 1'b0};
                    end
                default: ;
            endcase
        end
    end

endmodule

// ---- design/otpw_fuse_programmer.sv ----
// Wiper code register, fuse programming sequencer and tap decoder
//
// Overview of operation
// - Unlocked power-on presets wiper code to midscale 32
// - Instruction bit 7 set starts permanent programming
// - Read byte: two status bits, six code bits
// - Status 00 ready, 01 test, 10 fatal, 11 locked
// - Burn enables internal clock driving all fuse steps
// - Test fuse fails: halt, no data fuses, 01
// - Six data fuses, one per internal tick
// - Fuse mismatch: status 10, stop, retry allowed
// - Match: blow lock fuse; if it opens, status 11, refuse changes, else status 10
// - Locked part loads code from fuses at power-on
// - Out of reset, code selects exactly one of 64 taps
// - Code 0 is bottom tap, 63 is top
// - Address select pin supplies one address bit
// - Data line open-drain, clock line input only
// - Address byte: 010110, select bit, read/write
`timescale 1ns/1ns
`include "otpw_defs.svh"
module otpw_fuse_programmer
#(
    parameter int TICK_CYCLES = `OTPW_TICK_CYCLES
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire logic                   addr_select_pin,
    output otpw_pkg::otpw_fuse_t        fuse_blow,
    input  wire otpw_pkg::otpw_fuse_t   fuse_sense,
    output logic [`OTPW_CODE_W-1:0]     wiper_code,
    output logic [`OTPW_TAP_N-1:0]      tap_select,
    output logic [1:0]                  fuse_status,
    output logic                        prog_busy
);
    import otpw_pkg::*;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [`OTPW_TAP_N-1:0] tap_decode(input logic [`OTPW_CODE_W-1:0] c);
        tap_decode = '0;
        tap_decode[c] = 1'b1;
    endfunction

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    otpw_seq_t                  seq_reg;
    otpw_seq_t                  seq_next;
    logic [`OTPW_CODE_W-1:0]    wiper_code_reg;
    logic [`OTPW_CODE_W-1:0]    wiper_code_next;
    logic [1:0]                 status_reg;
    logic [1:0]                 status_next;
    logic [2:0]                 bit_idx_reg;
    logic [2:0]                 bit_idx_next;
    logic [15:0]                tick_cnt_reg;
    logic [15:0]                data_len_reg;
    logic [`OTPW_TAP_N-1:0]     tap_reg;
    otpw_fuse_t                 blow_reg;
    otpw_fuse_t                 blow_next;
    otpw_wr_t                   wr;

    // --------------------------------------------------------------
    // Serial slave
    // --------------------------------------------------------------
    wire [7:0] rd_byte = {status_reg, wiper_code_reg};

    otpw_serial_slave u_slave
    (
        .ref_clk         (ref_clk),
        .srst            (srst),
        .scl_in          (scl_in),
        .sda_in          (sda_in),
        .sda_out         (sda_out),
        .sda_oe          (sda_oe),
        .addr_select_pin (addr_select_pin),
        .rd_byte         (rd_byte),
        .wr              (wr)
    );

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    wire busy      = (seq_reg == SQ_TEST) || (seq_reg == SQ_DATA)
                   || (seq_reg == SQ_CMP) || (seq_reg == SQ_LOCK);
    wire accept_wr = wr.valid && (seq_reg == SQ_IDLE);
    wire burn_req  = accept_wr && wr.data[`OTPW_BURN_BIT];
    // Internal clock only runs while programming
    wire tick      = busy && (tick_cnt_reg == 16'(TICK_CYCLES - 1));
    wire code_ok   = (fuse_sense.data == wiper_code_reg);

    assign wiper_code  = wiper_code_reg;
    assign tap_select  = tap_reg;
    assign fuse_status = status_reg;
    assign prog_busy   = busy;
    assign fuse_blow   = blow_reg;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb
    begin
        seq_next        = seq_reg;
        wiper_code_next = wiper_code_reg;
        status_next     = status_reg;
        bit_idx_next    = bit_idx_reg;
        blow_next       = '0;
        unique case (seq_reg)
            // One cycle after reset release the fuse latches are read
            SQ_LOAD:
                if (fuse_sense.lock)
                begin
                    wiper_code_next = fuse_sense.data;
                    status_next     = `OTPW_ST_LOCKED;
                    seq_next        = SQ_DONE;
                end
                else
                    seq_next = SQ_IDLE;
            SQ_IDLE:
                if (accept_wr)
                begin
                    wiper_code_next = wr.data[`OTPW_CODE_HI:0];
                    if (burn_req)
                        seq_next = SQ_TEST;
                end
            SQ_TEST:
            begin
                blow_next.test = 1'b1;
                if (tick)
                begin
                    if (fuse_sense.test)
                    begin
                        bit_idx_next = 3'h0;
                        seq_next     = SQ_DATA;
                    end
                    else
                    begin
                        status_next = `OTPW_ST_TEST_FAIL;
                        seq_next    = SQ_IDLE;
                    end
                end
            end
            SQ_DATA:
            begin
                // Only the bits that are one are blown
                blow_next.data[bit_idx_reg] = wiper_code_reg[bit_idx_reg];
                if (tick)
                begin
                    bit_idx_next = bit_idx_reg + 3'h1;
                    if (bit_idx_reg == 3'h5)
                        seq_next = SQ_CMP;
                end
            end
            SQ_CMP:
                if (tick)
                begin
                    if (code_ok)
                        seq_next = SQ_LOCK;
                    else
                    begin
                        status_next = `OTPW_ST_FATAL;
                        seq_next    = SQ_IDLE;
                    end
                end
            SQ_LOCK:
            begin
                blow_next.lock = 1'b1;
                if (tick)
                begin
                    // A lock fuse that will not open is treated as fatal
                    status_next = fuse_sense.lock ? `OTPW_ST_LOCKED : `OTPW_ST_FATAL;
                    seq_next    = fuse_sense.lock ? SQ_DONE : SQ_IDLE;
                end
            end
            SQ_DONE: ;
            default: seq_next = SQ_LOAD;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            seq_reg        <= SQ_LOAD;
            wiper_code_reg <= `OTPW_CODE_MID;
            status_reg     <= `OTPW_ST_READY;
            bit_idx_reg    <= 3'h0;
            blow_reg       <= '0;
            tap_reg        <= '0;
        end
        else
        begin
            seq_reg        <= seq_next;
            wiper_code_reg <= wiper_code_next;
            status_reg     <= status_next;
            bit_idx_reg    <= bit_idx_next;
            blow_reg       <= blow_next;
            tap_reg        <= tap_decode(wiper_code_reg);
        end
    end

    // --------------------------------------------------------------
    // Internal clock divider
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || !busy || tick)
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end

    // Cycles spent in the data phase, for the six-step check
    always_ff @(posedge ref_clk)
    begin
        if (srst || (seq_reg != SQ_DATA))
            data_len_reg <= 16'h0000;
        else
            data_len_reg <= data_len_reg + 16'h0001;
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_midscale_preset: assert property (@(posedge ref_clk)
        srst |=> (wiper_code_reg == `OTPW_CODE_MID) && (status_reg == `OTPW_ST_READY))
        else $error("wiper not at midscale after reset");

    chk_burn_starts: assert property (@(posedge ref_clk) disable iff (srst)
        burn_req |=> (seq_reg == SQ_TEST) && (wiper_code_reg == $past(wr.data[5:0])))
        else $error("burn flag did not start programming");

    chk_tick_only_busy: assert property (@(posedge ref_clk) disable iff (srst)
        !busy |-> (tick_cnt_reg == 16'h0000) && !tick)
        else $error("internal clock running while idle");

    chk_test_fail_halt: assert property (@(posedge ref_clk) disable iff (srst)
        (seq_reg == SQ_TEST) && tick && !fuse_sense.test
        |=> (seq_reg == SQ_IDLE) && (status_reg == `OTPW_ST_TEST_FAIL)
            ##1 (blow_reg.data == 6'h00))
        else $error("test fuse failure not handled");

    chk_data_blow_gate: assert property (@(posedge ref_clk) disable iff (srst)
        (blow_reg.data != 6'h00) |-> $past(seq_reg) == SQ_DATA)
        else $error("data fuse blown outside data phase");

    chk_six_data_ticks: assert property (@(posedge ref_clk) disable iff (srst)
        (seq_reg == SQ_DATA) && tick && (bit_idx_reg == 3'h5)
        |-> (data_len_reg == 16'(6 * TICK_CYCLES - 1)) ##1 (seq_reg == SQ_CMP))
        else $error("data phase miscounted");

    chk_mismatch_fatal: assert property (@(posedge ref_clk) disable iff (srst)
        (seq_reg == SQ_CMP) && tick && !code_ok
        |=> (status_reg == `OTPW_ST_FATAL) && (seq_reg == SQ_IDLE))
        else $error("mismatch not reported as fatal");

    chk_lock_status: assert property (@(posedge ref_clk) disable iff (srst)
        (seq_reg == SQ_LOCK) && tick && fuse_sense.lock
        |=> (status_reg == `OTPW_ST_LOCKED) && (seq_reg == SQ_DONE))
        else $error("lock not reported");

    chk_fuse_reload: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && (seq_reg == SQ_LOAD) && fuse_sense.lock
        |=> (wiper_code_reg == $past(fuse_sense.data)) && (status_reg == `OTPW_ST_LOCKED))
        else $error("fuse code not loaded at power-on");

    chk_tap_position: assert property (@(posedge ref_clk) disable iff (srst)
        !srst |=> $onehot(tap_reg) && tap_reg[$past(wiper_code_reg)])
        else $error("tap select not one-hot at code");

    chk_write_refused: assert property (@(posedge ref_clk) disable iff (srst)
        wr.valid && (busy || (seq_reg == SQ_DONE)) |=> $stable(wiper_code_reg))
        else $error("write accepted while busy or locked");

endmodule

// ---- verif/otpw_bus_master.sv ----
// Behavioural two-wire bus master that sits on the far side of the wiper controller
`timescale 1ns/1ns
`include "otpw_defs.svh"
module otpw_bus_master
(
    input  wire logic        ref_clk,
    input  wire logic        sda,
    output logic             scl,
    output logic             sda_low,
    output logic             rd_valid,
    output logic [7:0]       rd_data
);
    localparam int Q = 4;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    task automatic wait_q(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Data changes only while the clock is low
    task automatic put_bit(input logic b, output logic s);
        sda_low <= ~b;
        wait_q(Q);
        scl <= 1'b1;
        wait_q(Q);
        s = sda;
        wait_q(Q);
        scl <= 1'b0;
        wait_q(Q);
    endtask

    task automatic start_cond();
        sda_low <= 1'b1;
        wait_q(Q);
        scl <= 1'b0;
        wait_q(Q);
    endtask

    // Released line rises to the pull-up level
    task automatic stop_cond();
        sda_low <= 1'b1;
        wait_q(Q);
        scl <= 1'b1;
        wait_q(Q);
        sda_low <= 1'b0;
        wait_q(2 * Q);
    endtask

    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic frame_write(input logic sel, input logic [7:0] d, output logic a0);
        logic a1;
        start_cond();
        byte_out({`OTPW_ADDR_PATTERN, sel, 1'b0}, a0);
        if (a0)
            byte_out(d, a1);
        stop_cond();
    endtask

    // Ends the read with a not-acknowledge so the slave lets go
    task automatic frame_read(input logic sel, output logic a0);
        logic [7:0] d;
        logic s;
        start_cond();
        byte_out({`OTPW_ADDR_PATTERN, sel, 1'b1}, a0);
        if (a0)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                put_bit(1'b1, s);
                d[i] = s;
            end
            put_bit(1'b1, s);
            rd_data <= d;
            rd_valid <= 1'b1;
            wait_q(1);
            rd_valid <= 1'b0;
        end
        stop_cond();
    endtask
endmodule

// ---- verif/tb_otp_wiper_fuse_programmer.sv ----
// Self-checking bench for the wiper controller with fuse and bus master models
`timescale 1ns/1ns
`include "otpw_defs.svh"
module tb_otp_wiper_fuse_programmer;
    import otpw_pkg::*;
    localparam int TICKS = 4;
    logic              ref_clk = 1'b0;
    logic              srst;
    logic              pin;
    logic              scl;
    logic              sda_low;
    logic              rd_valid;
    logic [7:0]        rd_data;
    logic              sda_out;
    logic              sda_oe;
    wire               sda;
    otpw_fuse_t        fuse_blow;
    otpw_fuse_t        fuse_sense = '0;
    otpw_fuse_t        fuse_ok;
    logic [5:0]        wiper_code;
    logic [63:0]       tap_select;
    logic [1:0]        fuse_status;
    logic              prog_busy;
    logic              busy_q = 1'b0;
    int                busy_n = 0;
    int                data_cyc = 0;
    int                miscompares = 0;
    int                compares = 0;
    logic [7:0]        notes[$];
    logic [31:0]       lfsr = 32'hEC70;
    logic [5:0]        code;
    int                d0;
    int                b0;

    always #2 ref_clk = ~ref_clk;
    assign sda = ~(sda_low | (sda_oe & ~sda_out));

    otpw_fuse_programmer #(.TICK_CYCLES(TICKS)) dut
    (
        .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(pin),
        .fuse_blow(fuse_blow), .fuse_sense(fuse_sense), .wiper_code(wiper_code),
        .tap_select(tap_select), .fuse_status(fuse_status), .prog_busy(prog_busy)
    );

    otpw_bus_master m
    (
        .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
        .rd_valid(rd_valid), .rd_data(rd_data)
    );

    // Fuses keep their state across resets, as on a real power cycle
    always @(posedge ref_clk)
    begin
        fuse_sense <= fuse_sense | (fuse_blow & fuse_ok);
        busy_q <= prog_busy;
        if (prog_busy === 1'b1 && busy_q !== 1'b1)
            busy_n <= busy_n + 1;
        if (fuse_blow.data !== 6'h00)
            data_cyc <= data_cyc + 1;
    end

    always @(posedge ref_clk)
        if (rd_valid === 1'b1 && notes.size() != 0)
            check("read_byte", notes.pop_front(), rd_data);

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic sel, input logic [7:0] d, input logic ack_exp);
        logic a0;
        m.frame_write(sel, d, a0);
        check("addr_ack", ack_exp, a0);
    endtask

    task automatic rd(input logic [7:0] exp);
        logic a0;
        notes.push_back(exp);
        m.frame_read(1'b1, a0);
        check("read_ack", 1'b1, a0);
    endtask

    // Bounded wait for one full programming run to finish
    task automatic wait_prog(input int n0);
        int k;
        for (k = 0; k < 400 && !(busy_n != n0 && prog_busy === 1'b0); k++)
            @(posedge ref_clk);
        if (k == 400)
        begin
            check("prog_done", 1'b1, 1'b0);
            tally_and_finish();
        end
    endtask

    task automatic power_cycle();
        srst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    initial
    begin
        srst <= 1'b1;
        pin <= 1'b1;
        fuse_ok <= '1;
        power_cycle();
        check("wiper_code", 6'h20, wiper_code);
        check("tap_select", 64'h1 << 32, tap_select);
        rd({`OTPW_ST_READY, 6'h20});
        wr(1'b0, 8'h05, 1'b0);
        check("wiper_code", 6'h20, wiper_code);
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            code = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : lfsr[5:0];
            wr(1'b1, {1'b0, lfsr[8], code}, 1'b1);
            check("wiper_code", code, wiper_code);
            check("tap_select", 64'h1 << code, tap_select);
        end
        rd({`OTPW_ST_READY, code});
        pin <= 1'b0;
        wr(1'b0, 8'h2A, 1'b1);
        check("wiper_code", 6'h2A, wiper_code);
        pin <= 1'b1;
        // Test fuse refuses to blow: data fuses must stay untouched
        fuse_ok <= '0;
        d0 = data_cyc;
        // Short runs end before the write frame does: count from before it
        b0 = busy_n;
        wr(1'b1, 8'h95, 1'b1);
        wait_prog(b0);
        check("fuse_status", `OTPW_ST_TEST_FAIL, fuse_status);
        check("data_strobes", d0, data_cyc);
        rd({`OTPW_ST_TEST_FAIL, 6'h15});
        // One data fuse stuck: compare fails, then a retry succeeds
        fuse_ok <= 8'hFE;
        b0 = busy_n;
        wr(1'b1, 8'h95, 1'b1);
        wait_prog(b0);
        check("fuse_status", `OTPW_ST_FATAL, fuse_status);
        check("fuse_data", 6'h14, fuse_sense.data);
        check("fuse_lock", 1'b0, fuse_sense.lock);
        rd({`OTPW_ST_FATAL, 6'h15});
        fuse_ok <= '1;
        b0 = busy_n;
        wr(1'b1, 8'h95, 1'b1);
        wait_prog(b0);
        check("fuse_status", `OTPW_ST_LOCKED, fuse_status);
        check("fuse_data", 6'h15, fuse_sense.data);
        check("fuse_lock", 1'b1, fuse_sense.lock);
        // Locked part refuses changes and new burns
        d0 = busy_n;
        wr(1'b1, 8'hBA, 1'b1);
        repeat (60) @(posedge ref_clk);
        check("burn_starts", d0, busy_n);
        check("wiper_code", 6'h15, wiper_code);
        rd({`OTPW_ST_LOCKED, 6'h15});
        power_cycle();
        check("wiper_code", 6'h15, wiper_code);
        check("fuse_status", `OTPW_ST_LOCKED, fuse_status);
        check("notes_left", 0, notes.size());
        tally_and_finish();
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
